// File: src/rco_pkg.sv
/*
  Package for the reset interrupt and clock output select block: register
  indices, field positions, reset values, timing counts and carrier types.
  Assumes a 20 MHz system clock and an APB master with 32-bit data.
*/
package rco_pkg;
  localparam int          ADDR_W        = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_IRQ_EN    = 16'hFF1D;
  localparam logic [15:0] IDX_IRQ_LAT   = 16'hFF1E;
  localparam logic [15:0] IDX_CLK_CFG   = 16'hFF1F;
  localparam logic [15:0] RST_IRQ_EN    = 16'h000E;
  localparam logic [15:0] RST_IRQ_LAT   = 16'h0000;
  localparam logic [5:0]  RST_CLK_CFG   = 6'h08;
  // Field positions
  localparam int          POS_HW_RST    = 4;
  localparam int          POS_RCVR_125  = 5;
  localparam int          POS_FREE_125  = 4;
  localparam int          POS_REF_PIN   = 3;
  localparam int          POS_HB_RCVR   = 2;
  localparam int          POS_HB_FREE   = 1;
  localparam int          POS_DIG_25    = 0;
  // Edges after reset release before straps are trusted
  localparam logic [1:0]  BOOT_CYCLES   = 2'h3;
  // Synchronised pin inputs
  localparam int          N_SYNC        = 6;
  localparam int          S_RCVR        = 0;
  localparam int          S_FREE        = 1;
  localparam int          S_XTAL        = 2;
  localparam int          S_PD_STRAP    = 3;
  localparam int          S_PD_CFG      = 4;
  localparam int          S_GIG         = 5;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } rco_apb_req_type;

  typedef struct packed {
    logic [N_SYNC-1:0] sync1;
    logic [N_SYNC-1:0] sync2;
    logic [1:0]        boot_cnt;
    logic [15:0]       irq_en;
    logic              hw_reset_event_latched;
    logic [5:0]        clk_cfg;
    logic              ref_div;
    logic              xtal_prev;
    logic              general_purpose_clock_output_pin;
    logic              ref_out;
    logic              int_n;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } rco_state_type;
endpackage

// File: src/rco_top.sv
/*
  Reset interrupt latch and clock output selection with an APB slave.
  Assumes clock sources and straps arrive as asynchronous pins, and that
  the pins are sampled at 20 MHz, so the clock outputs are sampled images.
*/
// How it works
// - Interrupt pin goes low while reset latch, enable bit 4 and power-down are set.
// - Enable bit 4 takes its default from the power-down strap after reset.
// - Interrupt only when power-down after reset is strapped or configured.
// - Status bit 4 sets after hardware reset, cleared by reading it.
// - Config bit 5 puts the recovered fast clock on the GP clock pin.
// - Config bit 4 puts the free-running fast clock on the GP clock pin.
// - Config bit 3, default one, drives crystal reference on reference pin.
// - With a 50 MHz crystal input, reference pin carries it divided by two.
// - Recovered heartbeat comes from reference or recovered clock by mode.
// - Config bit 2 puts the recovered heartbeat on the GP clock pin.
// - Free heartbeat comes from reference or free-running clock by mode.
// - Config bit 1 puts the free heartbeat on the GP clock pin.
// - Config bit 0 puts the digital reference copy on the GP clock pin.
`timescale 1ns/1ns
module rco_top (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [rco_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic                      RECOVERED_CLK,
  input  wire logic                      FREE_CLK,
  input  wire logic                      CRYSTAL_INPUT_PIN,
  input  wire logic                      CRYSTAL_50M_MODE,
  input  wire logic                      PD_STRAP,
  input  wire logic                      SOFT_POWERDOWN_AFTER_RESET_CONFIG,
  input  wire logic                      GIGABIT_MODE,
  output logic                           GENERAL_PURPOSE_CLOCK_OUTPUT_PIN,
  output logic                           REFERENCE_CLOCK_OUTPUT_PIN,
  output logic                           INT_N
);
  rco_pkg::rco_state_type   s_q;
  rco_pkg::rco_state_type   s_d;
  rco_pkg::rco_apb_req_type req;
  logic                     x50_s1_q;
  logic                     x50_q;
  logic                     setup;
  logic                     rd_acc;
  logic                     wr_acc;
  logic [15:0]              idx;
  logic                     powerdown;
  logic                     boot_done;
  logic                     ref25;
  logic                     hb_rcvr;
  logic                     hb_free;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                 paddr: PADDR, pwdata: PWDATA};
  assign setup  = req.psel && !req.penable;
  assign rd_acc = req.psel && req.penable && s_q.pready && !req.pwrite;
  assign wr_acc = req.psel && req.penable && s_q.pready && req.pwrite;
  assign idx    = 16'(req.paddr[rco_pkg::ADDR_W-1:2]);

  // 50 MHz crystal mode strap, two-stage sampler
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      x50_s1_q <= 1'b0;
      x50_q    <= 1'b0;
    end else begin
      x50_s1_q <= CRYSTAL_50M_MODE;
      x50_q    <= x50_s1_q;
    end
  end

  assign powerdown = s_q.sync2[rco_pkg::S_PD_STRAP] ||
                     s_q.sync2[rco_pkg::S_PD_CFG];
  assign boot_done = (s_q.boot_cnt == rco_pkg::BOOT_CYCLES - 2'h1);
  assign ref25     = x50_q ? s_q.ref_div
                           : s_q.sync2[rco_pkg::S_XTAL];
  assign hb_rcvr   = s_q.sync2[rco_pkg::S_GIG]
                     ? s_q.sync2[rco_pkg::S_RCVR] : ref25;
  assign hb_free   = s_q.sync2[rco_pkg::S_GIG]
                     ? s_q.sync2[rco_pkg::S_FREE] : ref25;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {GIGABIT_MODE, SOFT_POWERDOWN_AFTER_RESET_CONFIG, PD_STRAP,
                 CRYSTAL_INPUT_PIN, FREE_CLK, RECOVERED_CLK};
    s_d.sync2 = s_q.sync1;
    s_d.xtal_prev = s_q.sync2[rco_pkg::S_XTAL];
    // Halve the sampled 50 MHz crystal on its rising edges
    if (s_q.sync2[rco_pkg::S_XTAL] && !s_q.xtal_prev) begin
      s_d.ref_div = !s_q.ref_div;
    end
    if (s_q.boot_cnt != rco_pkg::BOOT_CYCLES) begin
      s_d.boot_cnt = s_q.boot_cnt + 2'h1;
    end
    // Bus: answer in the access phase, data chosen in setup
    s_d.pready  = setup;
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.prdata = 32'h0000_0000;
      unique case (idx)
        rco_pkg::IDX_IRQ_EN:  s_d.prdata = {16'h0000, s_q.irq_en};
        rco_pkg::IDX_IRQ_LAT: begin
          s_d.prdata[rco_pkg::POS_HW_RST] = s_q.hw_reset_event_latched;
        end
        rco_pkg::IDX_CLK_CFG: s_d.prdata = {26'h0, s_q.clk_cfg};
        default:              s_d.pslverr = 1'b1;
      endcase
    end
    if (!setup) begin
      s_d.pslverr = 1'b0;
    end
    if (wr_acc && idx == rco_pkg::IDX_IRQ_EN) begin
      s_d.irq_en = req.pwdata[15:0];
    end
    if (wr_acc && idx == rco_pkg::IDX_CLK_CFG) begin
      s_d.clk_cfg = req.pwdata[5:0];
    end
    if (rd_acc && idx == rco_pkg::IDX_IRQ_LAT) begin
      s_d.hw_reset_event_latched = 1'b0;
    end
    // Strap capture once samplers are valid; set beats read clear
    if (boot_done) begin
      s_d.irq_en[rco_pkg::POS_HW_RST] = s_q.sync2[rco_pkg::S_PD_STRAP];
      s_d.hw_reset_event_latched = 1'b1;
    end
    s_d.int_n = !(s_q.hw_reset_event_latched &&
                  s_q.irq_en[rco_pkg::POS_HW_RST] && powerdown);
    s_d.ref_out = s_q.clk_cfg[rco_pkg::POS_REF_PIN] && ref25;
    // Priority order only matters if software breaks the one-hot use
    if (s_q.clk_cfg[rco_pkg::POS_RCVR_125]) begin
      s_d.general_purpose_clock_output_pin = s_q.sync2[rco_pkg::S_RCVR];
    end else if (s_q.clk_cfg[rco_pkg::POS_FREE_125]) begin
      s_d.general_purpose_clock_output_pin = s_q.sync2[rco_pkg::S_FREE];
    end else if (s_q.clk_cfg[rco_pkg::POS_HB_RCVR]) begin
      s_d.general_purpose_clock_output_pin = hb_rcvr;
    end else if (s_q.clk_cfg[rco_pkg::POS_HB_FREE]) begin
      s_d.general_purpose_clock_output_pin = hb_free;
    end else if (s_q.clk_cfg[rco_pkg::POS_DIG_25]) begin
      s_d.general_purpose_clock_output_pin = ref25;
    end else begin
      s_d.general_purpose_clock_output_pin = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_q                        <= '0;
      s_q.irq_en                 <= rco_pkg::RST_IRQ_EN;
      s_q.hw_reset_event_latched <= rco_pkg::RST_IRQ_LAT[rco_pkg::POS_HW_RST];
      s_q.clk_cfg                <= rco_pkg::RST_CLK_CFG;
      s_q.int_n                  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA                           = s_q.prdata;
  assign PREADY                           = s_q.pready;
  assign PSLVERR                          = s_q.pslverr;
  assign GENERAL_PURPOSE_CLOCK_OUTPUT_PIN = s_q.general_purpose_clock_output_pin;
  assign REFERENCE_CLOCK_OUTPUT_PIN       = s_q.ref_out;
  assign INT_N                            = s_q.int_n;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_irq_cause;
    s_q.hw_reset_event_latched && s_q.irq_en[rco_pkg::POS_HW_RST]
      && powerdown;
  endsequence
  sequence s_lat_read;
    rd_acc && idx == rco_pkg::IDX_IRQ_LAT && !boot_done;
  endsequence

  sequence s_lat_setup;
    setup && idx == rco_pkg::IDX_IRQ_LAT;
  endsequence
  sequence s_en_setup;
    setup && idx == rco_pkg::IDX_IRQ_EN;
  endsequence
  sequence s_cfg_setup;
    setup && idx == rco_pkg::IDX_CLK_CFG;
  endsequence
  sequence s_unmapped_setup;
    setup && idx != rco_pkg::IDX_IRQ_EN && idx != rco_pkg::IDX_IRQ_LAT
      && idx != rco_pkg::IDX_CLK_CFG;
  endsequence

  a_int_follows_latch: assert property (
      s_irq_cause |=> !INT_N)
    else $error("interrupt pin not low with enabled latch");

  a_int_needs_pd: assert property (
      !powerdown |=> INT_N)
    else $error("interrupt without power-down configuration");

  a_boot_latch_set: assert property (
      $fell(RST) |-> ##[1:4] s_q.hw_reset_event_latched)
    else $error("reset event not latched after release");

  a_read_clears: assert property (
      s_lat_read |=> !s_q.hw_reset_event_latched ##1 INT_N)
    else $error("status read did not clear latch and pin");

  a_strap_default: assert property (
      boot_done |=> s_q.irq_en[rco_pkg::POS_HW_RST]
        == $past(s_q.sync2[rco_pkg::S_PD_STRAP]))
    else $error("enable bit not loaded from strap");

  a_ref_pin_off: assert property (
      !s_q.clk_cfg[rco_pkg::POS_REF_PIN] |=> !REFERENCE_CLOCK_OUTPUT_PIN)
    else $error("reference pin driven while disabled");

  a_div_toggle: assert property (
      x50_q && $rose(s_q.sync2[rco_pkg::S_XTAL])
        |=> s_q.ref_div != $past(s_q.ref_div))
    else $error("divider did not toggle");

  a_gp_free_sel: assert property (
      s_q.clk_cfg == 6'h10 |=> GENERAL_PURPOSE_CLOCK_OUTPUT_PIN
        == $past(s_q.sync2[rco_pkg::S_FREE]))
    else $error("free clock not on general purpose pin");

  a_gp_rcvr_sel: assert property (
      s_q.clk_cfg == 6'h20 |=> GENERAL_PURPOSE_CLOCK_OUTPUT_PIN
        == $past(s_q.sync2[rco_pkg::S_RCVR]))
    else $error("recovered clock not on general purpose pin");

  a_gp_dig_sel: assert property (
      s_q.clk_cfg == 6'h01
        |=> GENERAL_PURPOSE_CLOCK_OUTPUT_PIN == $past(ref25))
    else $error("digital reference not on general purpose pin");

  a_gp_hb_sel: assert property (
      s_q.clk_cfg == 6'h04
        |=> GENERAL_PURPOSE_CLOCK_OUTPUT_PIN == $past(hb_rcvr))
    else $error("recovered heartbeat not on general purpose pin");

  a_gp_hbf_sel: assert property (
      s_q.clk_cfg == 6'h02
        |=> GENERAL_PURPOSE_CLOCK_OUTPUT_PIN == $past(hb_free))
    else $error("free heartbeat not on general purpose pin");

  a_hb_source: assert property (
      !s_q.sync2[rco_pkg::S_GIG] |-> hb_rcvr == ref25 && hb_free == ref25)
    else $error("heartbeat source wrong outside gigabit mode");

  a_apb_ready: assert property (
      setup |=> PREADY ##1 !PREADY)
    else $error("access phase not answered in one cycle");

  a_int_no_latch: assert property (
      !s_q.hw_reset_event_latched |=> INT_N)
    else $error("interrupt pin low without latched event");

  a_int_no_enable: assert property (
      !s_q.irq_en[rco_pkg::POS_HW_RST] |=> INT_N)
    else $error("interrupt pin low while disabled");

  a_int_pd_strap: assert property (
      s_q.hw_reset_event_latched && s_q.irq_en[rco_pkg::POS_HW_RST]
        && s_q.sync2[rco_pkg::S_PD_STRAP] |=> !INT_N)
    else $error("strapped power-down did not raise interrupt");

  a_int_pd_cfg: assert property (
      s_q.hw_reset_event_latched && s_q.irq_en[rco_pkg::POS_HW_RST]
        && s_q.sync2[rco_pkg::S_PD_CFG] |=> !INT_N)
    else $error("configured power-down did not raise interrupt");

  a_latch_holds: assert property (
      s_q.hw_reset_event_latched
        && !(rd_acc && idx == rco_pkg::IDX_IRQ_LAT)
        |=> s_q.hw_reset_event_latched)
    else $error("reset latch lost without a status read");

  a_latch_quiet: assert property (
      !s_q.hw_reset_event_latched && !boot_done
        |=> !s_q.hw_reset_event_latched)
    else $error("reset latch set without a reset");

  a_boot_sets_latch: assert property (
      boot_done |=> s_q.hw_reset_event_latched)
    else $error("strap capture did not set the latch");

  a_boot_once: assert property (
      boot_done |=> !boot_done)
    else $error("strap capture repeated");

  a_boot_saturates: assert property (
      s_q.boot_cnt == rco_pkg::BOOT_CYCLES
        |=> s_q.boot_cnt == rco_pkg::BOOT_CYCLES)
    else $error("boot counter left its final value");

  a_lat_read_data: assert property (
      s_lat_setup |=> PRDATA
        == {27'h0, $past(s_q.hw_reset_event_latched), 4'h0})
    else $error("status read data wrong");

  a_en_read_data: assert property (
      s_en_setup |=> PRDATA == {16'h0000, $past(s_q.irq_en)})
    else $error("enable read data wrong");

  a_cfg_read_data: assert property (
      s_cfg_setup |=> PRDATA == {26'h0, $past(s_q.clk_cfg)})
    else $error("clock config read data wrong");

  a_unmapped_err: assert property (
      s_unmapped_setup |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_mapped_ok: assert property (
      setup && !(idx != rco_pkg::IDX_IRQ_EN
        && idx != rco_pkg::IDX_IRQ_LAT && idx != rco_pkg::IDX_CLK_CFG)
        |=> PREADY && !PSLVERR)
    else $error("mapped access refused");

  a_err_with_ready: assert property (
      PSLVERR |-> PREADY)
    else $error("error flag without ready");

  a_ready_after_setup: assert property (
      !setup |=> !PREADY)
    else $error("ready without a setup cycle");

  a_cfg_write: assert property (
      wr_acc && idx == rco_pkg::IDX_CLK_CFG
        |=> s_q.clk_cfg == $past(req.pwdata[5:0]))
    else $error("clock config write did not land");

  a_en_write: assert property (
      wr_acc && idx == rco_pkg::IDX_IRQ_EN && !boot_done
        |=> s_q.irq_en == $past(req.pwdata[15:0]))
    else $error("enable write did not land");

  a_cfg_stable: assert property (
      !(wr_acc && idx == rco_pkg::IDX_CLK_CFG) |=> $stable(s_q.clk_cfg))
    else $error("clock config changed without a write");

  a_en_stable: assert property (
      !(wr_acc && idx == rco_pkg::IDX_IRQ_EN) && !boot_done
        |=> $stable(s_q.irq_en))
    else $error("enable register changed without a write");

  a_ref_pin_on: assert property (
      s_q.clk_cfg[rco_pkg::POS_REF_PIN]
        |=> REFERENCE_CLOCK_OUTPUT_PIN == $past(ref25))
    else $error("reference pin not following reference");

  a_div_hold: assert property (
      !(s_q.sync2[rco_pkg::S_XTAL] && !s_q.xtal_prev)
        |=> $stable(s_q.ref_div))
    else $error("divider moved without a crystal edge");

  a_ref_direct: assert property (
      !x50_q && s_q.clk_cfg[rco_pkg::POS_REF_PIN]
        |=> REFERENCE_CLOCK_OUTPUT_PIN
          == $past(s_q.sync2[rco_pkg::S_XTAL]))
    else $error("reference pin not the crystal image");

  a_xtal_track: assert property (
      s_q.xtal_prev == $past(s_q.sync2[rco_pkg::S_XTAL]))
    else $error("crystal edge detector out of step");

  a_gp_idle: assert property (
      (s_q.clk_cfg & 6'h37) == 6'h00
        |=> !GENERAL_PURPOSE_CLOCK_OUTPUT_PIN)
    else $error("general purpose pin driven with no source");

  a_hb_gig: assert property (
      s_q.sync2[rco_pkg::S_GIG] |-> hb_rcvr == s_q.sync2[rco_pkg::S_RCVR]
        && hb_free == s_q.sync2[rco_pkg::S_FREE])
    else $error("heartbeat source wrong in gigabit mode");
endmodule

// File: sim/testbench.sv
/*
  Self-checking bench for the reset interrupt and clock output block.
  Assumes the APB slave answers on its own and clock pins are sampled.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk    = 0;
  logic        rst    = 1;
  logic        psel   = 0;
  logic        pen    = 0;
  logic        pwr    = 0;
  logic [17:0] paddr  = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rec    = 0;
  logic        fre    = 0;
  logic        xtal   = 0;
  logic        m50    = 0;
  logic        pds    = 0;
  logic        spd    = 0;
  logic        gig    = 1;
  logic        gp;
  logic        refo;
  logic        int_n;
  int          miscompares = 0;
  int          check_count = 0;

  rco_top dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RECOVERED_CLK(rec),
    .FREE_CLK(fre), .CRYSTAL_INPUT_PIN(xtal), .CRYSTAL_50M_MODE(m50),
    .PD_STRAP(pds), .SOFT_POWERDOWN_AFTER_RESET_CONFIG(spd),
    .GIGABIT_MODE(gig), .GENERAL_PURPOSE_CLOCK_OUTPUT_PIN(gp),
    .REFERENCE_CLOCK_OUTPUT_PIN(refo), .INT_N(int_n));

  initial begin
    forever #25 clk = !clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp32(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp1(string nm, logic e, logic g);
    cmp32(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic apb(logic wr, logic [15:0] idx, logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int   n;
    logic got;
    @(posedge clk);
    psel   <= 1;
    pwr    <= wr;
    paddr  <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    got = pready;
    rd  = prdata;
    err = pslverr;
    cmp1("pready", 1'b1, got);
    psel <= 0;
    pen  <= 0;
  endtask

  task automatic wr(logic [15:0] idx, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(string nm, logic [15:0] idx, logic [31:0] x, logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    cmp32(nm, x, r);
    cmp1({nm, " err"}, xe, e);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    wt(6);
  endtask

  task automatic t_defaults;
    rd("irq_en", rco_pkg::IDX_IRQ_EN, 32'h0000000E, 0);
    cmp1("int_n gated", 1'b1, int_n);
    rd("latch set", rco_pkg::IDX_IRQ_LAT, 32'h00000010, 0);
    rd("latch clear", rco_pkg::IDX_IRQ_LAT, 32'h00000000, 0);
    rd("clk_cfg", rco_pkg::IDX_CLK_CFG, 32'h00000008, 0);
    rd("unmapped", 16'hFF20, 32'h00000000, 1);
    wr(rco_pkg::IDX_CLK_CFG, 32'h0000FFFF);
    rd("cfg rsvd", rco_pkg::IDX_CLK_CFG, 32'h0000003F, 0);
    wr(rco_pkg::IDX_IRQ_EN, 32'h0000FFFF);
    rd("irq_en rw", rco_pkg::IDX_IRQ_EN, 32'h0000FFFF, 0);
  endtask

  task automatic t_irq_cfg;
    do_reset();
    wr(rco_pkg::IDX_IRQ_EN, 32'h0000001E);
    wt(4);
    cmp1("int_n no pd", 1'b1, int_n);
    @(posedge clk);
    spd <= 1;
    wt(6);
    cmp1("int_n pd cfg", 1'b0, int_n);
    rd("latch", rco_pkg::IDX_IRQ_LAT, 32'h00000010, 0);
    wt(2);
    cmp1("int_n cleared", 1'b1, int_n);
    @(posedge clk);
    spd <= 0;
  endtask

  task automatic t_irq_strap;
    @(posedge clk);
    pds <= 1;
    do_reset();
    rd("irq_en strap", rco_pkg::IDX_IRQ_EN, 32'h0000001E, 0);
    cmp1("int_n strap", 1'b0, int_n);
    wr(rco_pkg::IDX_IRQ_EN, 32'h0000000E);
    wt(3);
    cmp1("int_n masked", 1'b1, int_n);
    wr(rco_pkg::IDX_IRQ_EN, 32'h00000010);
    wt(3);
    cmp1("int_n unmasked", 1'b0, int_n);
    rd("latch", rco_pkg::IDX_IRQ_LAT, 32'h00000010, 0);
    rd("latch again", rco_pkg::IDX_IRQ_LAT, 32'h00000000, 0);
    cmp1("int_n read", 1'b1, int_n);
    @(posedge clk);
    pds <= 0;
  endtask

  task automatic drv(int s, logic v);
    @(posedge clk);
    rec  <= (s == 0) ? v : !v;
    fre  <= (s == 1) ? v : !v;
    xtal <= (s == 2) ? v : !v;
  endtask

  task automatic t_clocks;
    int   bits[7] = '{5, 4, 2, 1, 2, 1, 0};
    int   src[7]  = '{0, 1, 0, 1, 2, 2, 2};
    logic gg[7]   = '{1, 1, 1, 1, 0, 0, 1};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      gig <= gg[i];
      wr(rco_pkg::IDX_CLK_CFG, 32'h00000001 << bits[i]);
      for (int v = 0; v < 2; v++) begin
        drv(src[i], v[0]);
        wt(5);
        cmp1("gp pin", v[0], gp);
      end
    end
    wr(rco_pkg::IDX_CLK_CFG, 32'h00000008);
    for (int v = 0; v < 2; v++) begin
      drv(2, v[0]);
      wt(5);
      cmp1("ref pin", v[0], refo);
    end
    wr(rco_pkg::IDX_CLK_CFG, 32'h00000000);
    wt(5);
    cmp1("ref off", 1'b0, refo);
  endtask

  task automatic t_div;
    int   cnt;
    logic last;
    @(posedge clk);
    m50 <= 1;
    do_reset();
    cnt  = 0;
    last = refo;
    repeat (40) begin
      @(posedge clk);
      xtal <= !xtal;
      @(negedge clk);
      if (refo !== last)
        cnt++;
      last = refo;
    end
    cmp1("ref halved", 1'b1, cnt >= 18 && cnt <= 22);
  endtask

  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    wt(6);
    t_defaults();
    t_irq_cfg();
    t_irq_strap();
    t_clocks();
    t_div();
    wrap_up();
  end
endmodule
